/* File: tpw_port.sv */
// two-pin port with per-pin direction, pull-downs and wakeup, and one hysteresis enable for both pins
//////////////////////////////////////////////////////////////////////////////
module tpw_port (
    input  wire logic                   clk,          // core clock, 125 MHz
    input  wire logic                   rst_b,        // async reset, active low
    input  wire logic [5:0]             avs_address,  // word address
    input  wire logic                   avs_read,     // read request
    input  wire logic                   avs_write,    // write request
    input  wire logic [31:0]            avs_writedata, // write data
    output logic [31:0]                 avs_readdata, // read data
    output logic                        avs_waitrequest, // stall
    input  wire logic [1:0]             pin_in,       // pad levels {high, low}
    output logic [1:0]                  pin_out,      // pad drive values
    output logic [1:0]                  pin_oe,       // pad drive enables
    output tpw_pkg::tpw_pull_t          pin_pull,     // pull-down selects
    output logic                        hysteresis_enable, // input buffer mode
    output logic                        osc_enable,   // core oscillator on
    output logic                        core_halted,  // halt state level
    output logic                        pc_load,      // pulse: load pc
    output logic [11:0]                 pc_vector,    // vector for pc_load
    output logic                        pc_hold,      // pc may not advance
    output logic                        irq           // level interrupt
);
    //////////////////////////////////////////////////////////////////////////
    // reset release
    logic rs1_q;
    logic rs2_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    wire srst_b = rs2_q;

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [3:0]        dir_q;
    logic [3:0]        val_q;
    logic [3:0]        ictl_q;
    tpw_pkg::tpw_opt_t opt_q;
    logic [1:0]        ists_q;
    logic [1:0]        imsk_q;
    logic              rd_ack_q;
    logic [31:0]       rdata_q;

    wire sel_dir  = avs_address == tpw_pkg::OFF_PIN_DIRECTION;
    wire sel_val  = avs_address == tpw_pkg::OFF_PIN_VALUE;
    wire sel_ictl = avs_address == tpw_pkg::OFF_INPUT_CONTROL;
    wire sel_opt  = avs_address == tpw_pkg::OFF_OPTIONS;
    wire sel_ists = avs_address == tpw_pkg::OFF_IRQ_STATUS;
    wire sel_imsk = avs_address == tpw_pkg::OFF_IRQ_MASK;
    wire sel_core = avs_address == tpw_pkg::OFF_CORE_CTRL;
    wire wr       = avs_write;
    wire [1:0] dir_p = tpw_pkg::pick_pins(dir_q);
    wire [1:0] val_p = tpw_pkg::pick_pins(val_q);

    //////////////////////////////////////////////////////////////////////////
    // pin input sampling: three flops, accept when stages two and three agree
    logic [1:0] ps1_q;
    logic [1:0] ps2_q;
    logic [1:0] ps3_q;
    logic [1:0] pin_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ps1_q <= 2'h0;
            ps2_q <= 2'h0;
            ps3_q <= 2'h0;
            pin_q <= 2'h0;
        end else begin
            ps1_q <= pin_in;
            ps2_q <= ps1_q;
            ps3_q <= ps2_q;
            pin_q <= (ps2_q & ps3_q) | (pin_q & (ps2_q | ps3_q));
        end
    end
    wire [1:0] edge_p = pin_q ^ ((ps2_q & ps3_q) | (pin_q & (ps2_q | ps3_q)));

    //////////////////////////////////////////////////////////////////////////
    // halt / wake sequencing
    tpw_pkg::tpw_state_t          st_q;
    tpw_pkg::tpw_state_t          st_d;
    logic [tpw_pkg::STAB_CNT_W-1:0] stab_q;
    logic [1:0]                   wake_s;
    wire halt_req = wr & sel_core & avs_writedata[tpw_pkg::BIT_HALT_REQ];
    wire woke     = |wake_s;
    wire stab_done = stab_q == tpw_pkg::STAB_CNT_W'(tpw_pkg::STAB_CYCLES - 1);
    wire [1:0] arm = opt_q.wake_enable_option & {2{st_q == tpw_pkg::ST_HALT}};

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            tpw_pkg::ST_RUN:  if (halt_req) st_d = tpw_pkg::ST_HALT;
            tpw_pkg::ST_HALT: if (woke) st_d = tpw_pkg::ST_STAB;
            tpw_pkg::ST_STAB: if (stab_done) st_d = tpw_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge srst_b) begin
        if (!srst_b) begin
            st_q   <= tpw_pkg::ST_RUN;
            stab_q <= '0;
        end else begin
            st_q   <= st_d;
            stab_q <= (st_q == tpw_pkg::ST_STAB) ? stab_q + 1'b1 : '0;
        end
    end

    genvar g;
    for (g = 0; g < 2; g++) begin : g_wake
        tpw_wake_latch u_wl (
            .pin_in    (pin_in[g]),
            .arm       (arm[g]),
            .rise_en   (1'b1),
            .fall_en   (opt_q.dual_edge_wake_option),
            .clr_b     (st_q == tpw_pkg::ST_HALT),
            .clk       (clk),
            .rst_b     (srst_b),
            .wake_sync (wake_s[g])
        );
    end

    // clock is gated in halt; the latch restarts it once its level has passed two clk flops
    assign osc_enable  = (st_q != tpw_pkg::ST_HALT) | woke;
    assign core_halted = st_q == tpw_pkg::ST_HALT;
    assign pc_load     = (st_q == tpw_pkg::ST_RUN) & halt_req;
    assign pc_vector   = tpw_pkg::WAKE_VECTOR;
    assign pc_hold     = st_q != tpw_pkg::ST_RUN;

    //////////////////////////////////////////////////////////////////////////
    // register writes and interrupt status
    wire [1:0] ev_set = {|edge_p, (st_q == tpw_pkg::ST_STAB) & stab_done};
    always_ff @(posedge clk or negedge srst_b) begin
        if (!srst_b) begin
            dir_q  <= tpw_pkg::RST_DIRECTION;
            val_q  <= tpw_pkg::RST_VALUE;
            ictl_q <= tpw_pkg::RST_INPUT_CTRL;
            opt_q  <= tpw_pkg::RST_OPTIONS;
            ists_q <= 2'h0;
            imsk_q <= 2'h0;
        end else begin
            if (wr & sel_dir) dir_q <= tpw_pkg::place_pins(
                tpw_pkg::pick_pins(avs_writedata[3:0]));
            if (wr & sel_val) val_q <= tpw_pkg::place_pins(
                tpw_pkg::pick_pins(avs_writedata[3:0]));
            if (wr & sel_ictl) ictl_q <= {1'b0, avs_writedata[2], 2'h0};
            if (wr & sel_opt) opt_q <= avs_writedata[7:0];
            if (wr & sel_imsk) imsk_q <= avs_writedata[1:0];
            // set wins over write-one-to-clear
            ists_q <= (ists_q & ~({2{wr & sel_ists}} & avs_writedata[1:0])) | ev_set;
        end
    end
    assign irq = |(ists_q & imsk_q);

    //////////////////////////////////////////////////////////////////////////
    // pins
    assign pin_oe  = dir_p;
    assign pin_out = val_p;
    assign hysteresis_enable = ictl_q[tpw_pkg::BIT_HYST];
    // weak pull on a held-high pin is swapped for the larger one in halt
    wire [1:0] hold_hi = pin_q & {2{st_q == tpw_pkg::ST_HALT}};
    assign pin_pull.strong_pd  = opt_q.strong_pulldown_option & ~dir_p;
    assign pin_pull.weak_pd    = opt_q.weak_pulldown_option & ~dir_p & ~hold_hi;
    assign pin_pull.weak_pd_hi = opt_q.weak_pulldown_option & ~dir_p & hold_hi;

    //////////////////////////////////////////////////////////////////////////
    // read path: one wait cycle, then data from a flop
    wire [1:0] rd_pins = (dir_p & val_p) | (~dir_p & pin_q);
    wire [31:0] rd_mux =
        sel_dir  ? {28'h0, dir_q} :
        sel_val  ? {28'h0, tpw_pkg::place_pins(rd_pins)} :
        sel_ictl ? {28'h0, ictl_q} :
        sel_opt  ? {24'h0, opt_q} :
        sel_ists ? {30'h0, ists_q} :
        sel_imsk ? {30'h0, imsk_q} :
        sel_core ? {30'h0, core_halted, 1'b0} : 32'h0;

    always_ff @(posedge clk or negedge srst_b) begin
        if (!srst_b) begin
            rd_ack_q <= 1'b0;
            rdata_q  <= 32'h0;
        end else begin
            rd_ack_q <= avs_read & ~rd_ack_q;
            if (avs_read & ~rd_ack_q) rdata_q <= rd_mux;
        end
    end
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = avs_read & ~rd_ack_q;
endmodule : tpw_port

/* File: tpw_pkg.sv */
// package for the two-pin port with wakeup
package tpw_pkg;
    localparam int unsigned CLK_HZ         = 125000000;
    localparam int unsigned STAB_TIME_US   = 352;
    localparam int unsigned STAB_CYCLES    = (CLK_HZ / 1000000) * STAB_TIME_US;
    localparam int unsigned STAB_CNT_W     = 16;

    localparam logic [5:0] OFF_PIN_DIRECTION = 6'h02;
    localparam logic [5:0] OFF_PIN_VALUE     = 6'h03;
    localparam logic [5:0] OFF_INPUT_CONTROL = 6'h11;
    localparam logic [5:0] OFF_OPTIONS       = 6'h20;
    localparam logic [5:0] OFF_IRQ_STATUS    = 6'h21;
    localparam logic [5:0] OFF_IRQ_MASK      = 6'h22;
    localparam logic [5:0] OFF_CORE_CTRL     = 6'h23;

    localparam int unsigned BIT_LOW          = 0;
    localparam int unsigned BIT_HIGH         = 3;
    localparam int unsigned BIT_HYST         = 2;
    localparam int unsigned BIT_HALT_REQ     = 0;
    localparam int unsigned BIT_HALTED       = 1;
    localparam int unsigned BIT_IRQ_WAKE     = 0;
    localparam int unsigned BIT_IRQ_EDGE     = 1;

    localparam logic [3:0]  RST_DIRECTION    = 4'h0;
    localparam logic [3:0]  RST_VALUE        = 4'h0;
    localparam logic [3:0]  RST_INPUT_CTRL   = 4'h0;
    localparam logic [7:0]  RST_OPTIONS      = 8'h00;
    localparam logic [11:0] WAKE_VECTOR      = 12'h004;

    typedef struct packed {
        logic [1:0] strong_pulldown_option; // per pin: [1]=high pin, [0]=low pin
        logic [1:0] weak_pulldown_option;
        logic [1:0] wake_enable_option;
        logic       dual_edge_wake_option;
        logic       spare;
    } tpw_opt_t;

    typedef struct packed {
        logic [1:0] strong_pd;   // 50k on
        logic [1:0] weak_pd;     // 1M on
        logic [1:0] weak_pd_hi;  // 3.3M on
    } tpw_pull_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_STAB
    } tpw_state_t;

    function automatic logic [1:0] pick_pins(input logic [3:0] r);
        pick_pins = {r[BIT_HIGH], r[BIT_LOW]};
    endfunction : pick_pins

    function automatic logic [3:0] place_pins(input logic [1:0] p);
        place_pins = {p[1], 2'h0, p[0]};
    endfunction : place_pins
endpackage : tpw_pkg

/* File: tpw_wake_latch.sv */
// asynchronous wakeup edge catcher, one per pin
module tpw_wake_latch (
    input  wire logic pin_in,     // raw pin level
    input  wire logic arm,        // enabled and halted
    input  wire logic rise_en,    // 1 always, catch rising edges
    input  wire logic fall_en,    // double-edge option
    input  wire logic clr_b,      // synchronous release from core, active low
    input  wire logic clk,        // core clock
    input  wire logic rst_b,      // reset, active low
    output logic      wake_sync   // synchronised wake level
);
    logic rise_q;
    logic fall_q;
    logic s1_q;
    logic s2_q;
    wire  rise_rst_b = rst_b & clr_b & arm;

    // the pin itself clocks these so edges are caught with the clock stopped
    always_ff @(posedge pin_in or negedge rise_rst_b) begin
        if (!rise_rst_b) rise_q <= 1'b0;
        else rise_q <= rise_en;
    end

    always_ff @(negedge pin_in or negedge rise_rst_b) begin
        if (!rise_rst_b) fall_q <= 1'b0;
        else fall_q <= fall_en;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= rise_q | fall_q;
            s2_q <= s1_q;
        end
    end

    assign wake_sync = s2_q;
endmodule : tpw_wake_latch

/* File: tpw_port_sva.sv */
// concurrent checks on the two-pin port's ports
module tpw_port_sva (
    input wire logic               clk,               // clock
    input wire logic               rst_b,             // reset
    input wire logic [5:0]         avs_address,       // address
    input wire logic               avs_read,          // read
    input wire logic               avs_write,         // write
    input wire logic [31:0]        avs_writedata,     // wdata
    input wire logic [31:0]        avs_readdata,      // rdata
    input wire logic               avs_waitrequest,   // stall
    input wire logic [1:0]         pin_out,           // drive
    input wire logic [1:0]         pin_oe,            // enable
    input tpw_pkg::tpw_pull_t      pin_pull,          // pulls
    input wire logic               hysteresis_enable, // hyst
    input wire logic               osc_enable,        // osc
    input wire logic               core_halted,       // halt
    input wire logic               pc_load,           // load
    input wire logic [11:0]        pc_vector,         // vector
    input wire logic               pc_hold            // hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [31:0] wd_q;
    logic [15:0] cnt_q;
    wire         wr_ok = avs_write && !avs_waitrequest;
    wire  [1:0]  pd = pin_pull.strong_pd | pin_pull.weak_pd | pin_pull.weak_pd_hi;
    // counts running stabilisation cycles, zero while halted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_q  <= 32'h0;
            cnt_q <= 16'h0;
        end else begin
            wd_q  <= avs_writedata;
            cnt_q <= (pc_hold && osc_enable) ? cnt_q + 16'h1 : 16'h0;
        end
    end
    AST_DIR: assert property (wr_ok && avs_address == 6'h02 |=> pin_oe == {wd_q[3], wd_q[0]})
        else $error("direction not applied");
    AST_LATCH: assert property (wr_ok && avs_address == 6'h03 |=> pin_out == {wd_q[3], wd_q[0]})
        else $error("output latch not loaded");
    AST_RD_LATCH: assert property (avs_read && !avs_waitrequest && avs_address == 6'h03
        && pin_oe == 2'h3 |-> {avs_readdata[3], avs_readdata[0]} == pin_out)
        else $error("output read not latch");
    AST_PULL_OFF: assert property ((pin_oe & pd) == 2'h0)
        else $error("pull-down on output pin");
    AST_HYST: assert property (wr_ok && avs_address == 6'h11 |=> hysteresis_enable == wd_q[2])
        else $error("hysteresis bit wrong");
    AST_SWAP: assert property (pin_pull.weak_pd_hi != 2'h0 |-> core_halted)
        else $error("high pull-down outside halt");
    AST_OSC: assert property (!osc_enable |-> core_halted)
        else $error("oscillator off while running");
    AST_WAKE: assert property ($rose(osc_enable) |-> pc_hold && pc_vector == 12'h004)
        else $error("wake without vector hold");
    AST_HALT: assert property (pc_load |-> pc_vector == 12'h004 ##[1:2] core_halted && pc_hold)
        else $error("halt entry wrong");
    AST_STAB: assert property ($fell(pc_hold) |-> cnt_q inside {[43998:44002]})
        else $error("stabilisation time wrong");
endmodule : tpw_port_sva
bind tpw_port tpw_port_sva u_sva (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_out, .pin_oe, .pin_pull,
    .hysteresis_enable, .osc_enable, .core_halted, .pc_load, .pc_vector, .pc_hold);

/* File: tpw_buttons.sv */
// push buttons to supply on the two port pins
module tpw_buttons (
    input wire logic          clk,     // pattern clock
    input wire logic [1:0]    press,   // button held
    input wire logic [1:0]    pin_out, // port drive
    input wire logic [1:0]    pin_oe,  // port enable
    input tpw_pkg::tpw_pull_t pin_pull, // port pulls
    output logic [1:0]        pin_in   // pad level
);
    logic       flt_q = 1'b0;
    wire  [1:0] pd = pin_pull.strong_pd | pin_pull.weak_pd | pin_pull.weak_pd_hi;
    // an open pad with no pull wanders, so never a steady level
    always @(posedge clk) flt_q <= ~flt_q;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & press) | (~pin_oe & ~press & ~pd & {2{flt_q}});
endmodule : tpw_buttons

/* File: tb_tpw_port.sv */
// self-checking bench for the two-pin port
module tb_tpw_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    logic [5:0]         avs_address = 6'h0;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = 32'h0;
    logic [31:0]        avs_readdata, q;
    logic               avs_waitrequest, hysteresis_enable, osc_enable;
    logic               core_halted, pc_load, pc_hold, irq;
    logic [1:0]         pin_in, pin_out, pin_oe;
    logic [1:0]         press = 2'h0;
    logic [11:0]        pc_vector;
    tpw_pkg::tpw_pull_t pin_pull;
    int                 err_total = 0;
    int                 check_count = 0;
    int                 cyc = 0;
    tpw_port u_dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .pin_pull,
        .hysteresis_enable, .osc_enable, .core_halted, .pc_load, .pc_vector, .pc_hold, .irq);
    tpw_buttons u_btn (.clk, .press, .pin_out, .pin_oe, .pin_pull, .pin_in);
    always #4 clk = ~clk;
    //////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("mismatches %0d of %0d checks", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // entered just after a rising edge; waitrequest and read data taken at the rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            $display("CHECK FAILED at %0t: bus answer timed out", $time);
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd
    task automatic wake_wait;
        int n;
        n = 0;
        while (osc_enable !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (pc_hold !== 1'b0 && n < 50000) begin
            @(posedge clk);
            n++;
        end
        check(32'(n > 43900 && n < 44100), 32'h1);
        repeat (3) @(posedge clk);
    endtask : wake_wait
    always @(posedge clk) begin
        cyc++;
        if (cyc == 98000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(6'h02, 32'h0);
        rd(6'h11, 32'h0);
        bus(1'b1, 6'h3F, 32'hF);
        rd(6'h3F, 32'h0);
        bus(1'b1, 6'h02, 32'h9);
        check(32'(pin_oe), 32'h3);
        bus(1'b1, 6'h03, 32'hF);
        check(32'(pin_out), 32'h3);
        rd(6'h03, 32'h9);
        bus(1'b1, 6'h03, 32'h1);
        rd(6'h03, 32'h1);
        bus(1'b1, 6'h20, 32'h64);
        check(32'(pin_pull), 32'h0);
        bus(1'b1, 6'h02, 32'h1);
        check(32'(pin_pull), 32'h08);
        bus(1'b1, 6'h02, 32'h0);
        check(32'(pin_pull), 32'h18);
        press <= 2'h2;
        repeat (5) @(posedge clk);
        rd(6'h03, 32'h8);
        bus(1'b1, 6'h11, 32'h4);
        check(32'(hysteresis_enable), 32'h1);
        bus(1'b1, 6'h22, 32'h1);
        bus(1'b1, 6'h23, 32'h1);
        check(32'({core_halted, osc_enable}), 32'h2);
        press <= 2'h0;
        repeat (20) @(posedge clk);
        check(32'(osc_enable), 32'h0);
        press <= 2'h3;
        wake_wait();
        check(32'(irq), 32'h1);
        bus(1'b1, 6'h21, 32'h3);
        check(32'(irq), 32'h0);
        // second halt: high pin held on weak pull, woken by release
        bus(1'b1, 6'h20, 32'h6A);
        bus(1'b1, 6'h23, 32'h1);
        check(32'(pin_pull.weak_pd_hi), 32'h2);
        press <= 2'h1;
        wake_wait();
        summarize();
    end
endmodule : tb_tpw_port
